// [pkg/cmt_pkg.sv]
package cmt_pkg;
  localparam int ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTL_ZERO   = 16'hffa0;
  localparam logic [15:0] IDX_CTL_STATUS = 16'hffa1;
  localparam logic [15:0] IDX_COUNTER    = 16'hffa2;
  localparam logic [15:0] IDX_CONST_A    = 16'hffa3;
  localparam logic [15:0] IDX_CONST_B    = 16'hffa4;
  localparam logic [15:0] IDX_CTL_ONE    = 16'hffa5;
  localparam logic [15:0] IDX_EVT_STATUS = 16'hffa6;
  localparam logic [15:0] IDX_EVT_CLEAR  = 16'hffa7;
  localparam logic [15:0] IDX_EVT_ENABLE = 16'hffa8;
  // timer_control_zero fields
  localparam int BIT_MATCH_B_IE  = 7;
  localparam int BIT_MATCH_A_IE  = 6;
  localparam int BIT_OVF_IE      = 5;
  localparam int POS_CLEAR_SEL   = 3;
  localparam int POS_CLOCK_SEL   = 0;
  // timer_control_status fields
  localparam int BIT_MATCH_B_FLAG = 7;
  localparam int BIT_MATCH_A_FLAG = 6;
  localparam int BIT_OVF_FLAG     = 5;
  localparam int BIT_STATUS_ONE   = 4;
  localparam int POS_OUT_SEL_B    = 2;
  localparam int POS_OUT_SEL_A    = 0;
  // timer_control_one fields
  localparam int POS_TRIG_EDGE   = 3;
  localparam int BIT_TRIG_ENABLE = 2;
  localparam int BIT_INT_CLK_SEL = 0;
  // event register bits
  localparam int EVT_MATCH_A = 0;
  localparam int EVT_MATCH_B = 1;
  localparam int EVT_OVF     = 2;
  // reset values
  localparam logic [7:0] RST_CTL_ZERO = 8'h00;
  localparam logic [7:0] RST_CTL_ONE  = 8'h00;
  localparam logic [7:0] RST_OUT_SEL  = 8'h00;
  localparam logic [7:0] RST_CONST    = 8'hff;
  localparam logic [7:0] RST_COUNTER  = 8'h00;
  localparam logic [6:0] RST_PRESCALE = 7'h00;
  // prescaler length (phi/128 is the slowest tap)
  localparam int PRESCALE_W = 7;
  typedef enum logic [1:0] {CLR_NONE, CLR_MATCH_A, CLR_MATCH_B, CLR_TRIG}
    cmt_clear_t;
  typedef enum logic [1:0] {OUT_KEEP, OUT_LOW, OUT_HIGH, OUT_TOGGLE}
    cmt_out_t;
endpackage

// [src/cmt_timer.sv]
// Operation
// RQ1: match B flag raises no interrupt while its enable bit is 0.
// RQ2: match A flag raises no interrupt while its enable bit is 0.
// RQ3: overflow enable bit blocks or passes overflow flag interrupts.
// RQ4: clear select picks counter clear condition; 00 never clears.
// RQ5: clock select 011 with internal select 1 counts phi/128 falling edges.
// RQ6: match B flag sets when counter equals compare constant B.
// RQ7: match A flag sets when counter equals compare constant A.
// RQ8: overflow flag sets when the counter overflows.
// RQ9: overflow flag clears only after read as 1 then written 0.
// RQ10: output select B sets pin on match B; 00 leaves it.
// RQ11: output select A sets pin on match A; 00 leaves it.
// RQ12: trigger edge select picks active edge; 00 ignores trigger.
// RQ13: trigger enable 0: pin never starts counting, match clear never halts.
// RQ14: internal clock select is bit 0 of control one, used with clock select.
// RQ15: interrupt asserted while any flag and its enable are both 1.
// RQ16: writing 1 to a flag has no effect; only hardware sets flags.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmt_timer
  import cmt_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cmt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      triggerInputPin,
  output logic                           timerOutputPin,
  output logic                           timerIrq
);
  import cmt_pkg::*;

  logic [7:0]            ctlZeroReg, ctlZeroNext;
  logic [7:0]            ctlOneReg, ctlOneNext;
  logic [7:0]            outSelReg, outSelNext;
  logic [7:0]            constAReg, constANext;
  logic [7:0]            constBReg, constBNext;
  logic [7:0]            counterReg, counterNext;
  logic [2:0]            flagReg, flagNext;
  logic [2:0]            armReg, armNext;
  logic [2:0]            evtReg, evtNext;
  logic [2:0]            evtEnReg, evtEnNext;
  logic [PRESCALE_W-1:0] presReg, presNext;
  logic                  pinReg, pinNext;
  logic                  runReg, runNext;
  logic                  eqAPrevReg, eqBPrevReg;
  logic                  trigS1Reg, trigS2Reg, trigS3Reg;
  logic [31:0]           rdataReg, rdataNext;

  logic                  setupPh, accessPh, hit, wrDone, rdDone;
  logic [15:0]           idx;
  logic [7:0]            wb;
  logic [7:0]            statusView;
  logic [PRESCALE_W-1:0] divMask;
  logic                  tick, counting, eqA, eqB, matchA, matchB, ovfEvt;
  logic                  trigEdge, clearNow;
  logic [2:0]            flagEvt, flagEn;
  logic [1:0]            trigSel;
  cmt_clear_t            clrSel;
  cmt_out_t              osA, osB;

  assign idx      = paddr[ADDR_W-1:2];
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wb       = pwdata[7:0];
  assign hit      = (paddr[1:0] == 2'b00) &&
                    (idx inside {IDX_CTL_ZERO, IDX_CTL_STATUS, IDX_COUNTER,
                                 IDX_CONST_A, IDX_CONST_B, IDX_CTL_ONE,
                                 IDX_EVT_STATUS, IDX_EVT_CLEAR,
                                 IDX_EVT_ENABLE});
  assign pready   = accessPh;
  assign pslverr  = accessPh && !hit;
  assign wrDone   = accessPh && pwrite && hit;
  assign rdDone   = accessPh && !pwrite && hit;
  assign prdata   = rdataReg;

  assign clrSel  = cmt_clear_t'(ctlZeroReg[POS_CLEAR_SEL +: 2]);
  assign osA     = cmt_out_t'(outSelReg[POS_OUT_SEL_A +: 2]);
  assign osB     = cmt_out_t'(outSelReg[POS_OUT_SEL_B +: 2]);
  assign trigSel = ctlOneReg[POS_TRIG_EDGE +: 2];

  assign statusView = {flagReg[2], flagReg[1], flagReg[0], 1'b1,
                       outSelReg[3:0]};

  // prescaler tap from clock select plus internal select
  always_comb
  begin
    divMask = '0;
    case (ctlZeroReg[POS_CLOCK_SEL +: 3])
      3'b001: divMask = ctlOneReg[BIT_INT_CLK_SEL] ? 7'h07 : 7'h03; // [RQ14]
      3'b010: divMask = ctlOneReg[BIT_INT_CLK_SEL] ? 7'h1f : 7'h0f; // [RQ14]
      3'b011: divMask = ctlOneReg[BIT_INT_CLK_SEL] ? 7'h7f : 7'h3f; // [RQ5]
      default: divMask = '0;
    endcase
  end
  // falling edge of the divided clock: all low bits wrap together
  assign tick = (divMask != '0) && ((presReg & divMask) == divMask); // [RQ5]

  // trigger edge detection on synchronised pin; 00 ignores it
  always_comb
  begin
    case (trigSel)
      2'b01:   trigEdge = trigS2Reg && !trigS3Reg;              // [RQ12]
      2'b10:   trigEdge = !trigS2Reg && trigS3Reg;              // [RQ12]
      2'b11:   trigEdge = trigS2Reg != trigS3Reg;               // [RQ12]
      default: trigEdge = 1'b0;                                 // [RQ12]
    endcase
  end

  assign counting = !ctlOneReg[BIT_TRIG_ENABLE] || runReg;     // [RQ13]
  assign eqA      = counterReg == constAReg;
  assign eqB      = counterReg == constBReg;
  assign matchA   = eqA && !eqAPrevReg;                          // [RQ7]
  assign matchB   = eqB && !eqBPrevReg;                          // [RQ6]
  assign ovfEvt   = tick && counting && counterReg == 8'hff;     // [RQ8]
  assign flagEvt  = {matchB, matchA, ovfEvt};

  always_comb
  begin
    case (clrSel)                                                // [RQ4]
      CLR_MATCH_A: clearNow = matchA;
      CLR_MATCH_B: clearNow = matchB;
      CLR_TRIG:    clearNow = trigEdge;
      default:     clearNow = 1'b0;
    endcase
  end

  assign flagEn = {ctlZeroReg[BIT_MATCH_B_IE], ctlZeroReg[BIT_MATCH_A_IE],
                   ctlZeroReg[BIT_OVF_IE]};
  assign timerIrq = |(flagReg & flagEn)  // [RQ1] [RQ2] [RQ3] [RQ15]
                    | |(evtReg & evtEnReg);

  always_comb
  begin
    ctlZeroNext = ctlZeroReg;
    ctlOneNext  = ctlOneReg;
    outSelNext  = outSelReg;
    constANext  = constAReg;
    constBNext  = constBReg;
    counterNext = counterReg;
    flagNext    = flagReg;
    armNext     = armReg;
    evtNext     = evtReg;
    evtEnNext   = evtEnReg;
    presNext    = presReg + 1'b1;
    pinNext     = pinReg;
    runNext     = runReg;
    rdataNext   = rdataReg;

    if (setupPh && !pwrite)
    begin
      rdataNext = '0;
      case (idx)
        IDX_CTL_ZERO:   rdataNext[7:0] = ctlZeroReg;
        IDX_CTL_STATUS: rdataNext[7:0] = statusView;
        IDX_COUNTER:    rdataNext[7:0] = counterReg;
        IDX_CONST_A:    rdataNext[7:0] = constAReg;
        IDX_CONST_B:    rdataNext[7:0] = constBReg;
        IDX_CTL_ONE:    rdataNext[7:0] = ctlOneReg;
        IDX_EVT_STATUS: rdataNext[2:0] = evtReg;
        IDX_EVT_ENABLE: rdataNext[2:0] = evtEnReg;
        default:        rdataNext = '0;
      endcase
    end

    // flag read as 1 arms its clear
    if (rdDone && idx == IDX_CTL_STATUS)
      armNext = armReg | rdataReg[7:5];                          // [RQ9]

    if (wrDone)
    begin
      case (idx)
        IDX_CTL_ZERO:   ctlZeroNext = wb;
        IDX_CTL_ONE:    ctlOneNext = wb;
        IDX_CONST_A:    constANext = wb;
        IDX_CONST_B:    constBNext = wb;
        IDX_COUNTER:    counterNext = wb;
        IDX_EVT_ENABLE: evtEnNext = wb[2:0];
        IDX_EVT_CLEAR:  evtNext = evtReg & ~wb[2:0];
        IDX_CTL_STATUS:
        begin
          outSelNext = {4'h0, wb[3:0]};
          // zero on an armed flag clears it; a one is ignored
          flagNext = flagReg & ~(armReg & ~wb[7:5]);  // [RQ9] [RQ16]
          armNext  = '0;
        end
        default: ;
      endcase
    end

    // counter advance and clear; a bus write to the counter wins
    if (!(wrDone && idx == IDX_COUNTER))
    begin
      if (clearNow)
        counterNext = '0;                                        // [RQ4]
      else if (tick && counting)
        counterNext = counterReg + 1'b1;
    end

    // trigger start and match-clear halt only with trigger enabled
    if (ctlOneReg[BIT_TRIG_ENABLE])                              // [RQ13]
    begin
      if (trigEdge)
        runNext = 1'b1;
      else if (clearNow && clrSel != CLR_TRIG)
        runNext = 1'b0;
    end
    else
      runNext = 1'b0;

    // hardware set wins over any clear in the same cycle
    flagNext = flagNext | flagEvt;  // [RQ6] [RQ7] [RQ8]
    evtNext  = evtNext | {ovfEvt, matchB, matchA};

    // output pin: match A first, match B overrides
    if (matchA)
    begin
      case (osA)                                                 // [RQ11]
        OUT_LOW:    pinNext = 1'b0;
        OUT_HIGH:   pinNext = 1'b1;
        OUT_TOGGLE: pinNext = !pinReg;
        default:    pinNext = pinReg;
      endcase
    end
    if (matchB)
    begin
      case (osB)                                                 // [RQ10]
        OUT_LOW:    pinNext = 1'b0;
        OUT_HIGH:   pinNext = 1'b1;
        OUT_TOGGLE: pinNext = !pinNext;
        default:    pinNext = pinNext;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctlZeroReg <= RST_CTL_ZERO;
      ctlOneReg  <= RST_CTL_ONE;
      outSelReg  <= RST_OUT_SEL;
      constAReg  <= RST_CONST;
      constBReg  <= RST_CONST;
      counterReg <= RST_COUNTER;
      flagReg    <= '0;
      armReg     <= '0;
      evtReg     <= '0;
      evtEnReg   <= '0;
      presReg    <= RST_PRESCALE;
      pinReg     <= 1'b0;
      runReg     <= 1'b0;
      eqAPrevReg <= 1'b0;
      eqBPrevReg <= 1'b0;
      trigS1Reg  <= 1'b0;
      trigS2Reg  <= 1'b0;
      trigS3Reg  <= 1'b0;
      rdataReg   <= '0;
    end
    else
    begin
      ctlZeroReg <= ctlZeroNext;
      ctlOneReg  <= ctlOneNext;
      outSelReg  <= outSelNext;
      constAReg  <= constANext;
      constBReg  <= constBNext;
      counterReg <= counterNext;
      flagReg    <= flagNext;
      armReg     <= armNext;
      evtReg     <= evtNext;
      evtEnReg   <= evtEnNext;
      presReg    <= presNext;
      pinReg     <= pinNext;
      runReg     <= runNext;
      eqAPrevReg <= eqA;
      eqBPrevReg <= eqB;
      trigS1Reg  <= triggerInputPin;
      trigS2Reg  <= trigS1Reg;
      trigS3Reg  <= trigS2Reg;
      rdataReg   <= rdataNext;
    end
  end

  assign timerOutputPin = pinReg;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  match_b_gate_a: assert property (  // [RQ1]
    flagReg[2] && !flagEn[2] && !(|(flagReg[1:0] & flagEn[1:0]))
    && !(|(evtReg & evtEnReg)) |-> !timerIrq)
    else $error("match B flag raised interrupt while disabled");
  match_a_gate_a: assert property (  // [RQ2]
    flagReg[1] && !flagEn[1] && !(flagReg[2] && flagEn[2])
    && !(flagReg[0] && flagEn[0]) && !(|(evtReg & evtEnReg))
    |-> !timerIrq)
    else $error("match A flag raised interrupt while disabled");
  ovf_irq_pass_a: assert property (  // [RQ3]
    $rose(flagReg[0]) && ctlZeroReg[BIT_OVF_IE] |-> timerIrq)
    else $error("overflow interrupt not passed");
  irq_any_a: assert property (  // [RQ15]
    |(flagReg & flagEn) |-> timerIrq)
    else $error("enabled flag without interrupt");
  no_clear_a: assert property (  // [RQ4]
    clrSel == CLR_NONE && counterReg != 8'hff && counterReg != 8'h00
    && !(wrDone && idx == IDX_COUNTER) |=> counterReg != 8'h00)
    else $error("counter cleared with clearing disabled");
  div128_tick_a: assert property (  // [RQ5]
    ctlZeroReg[2:0] == 3'b011 && ctlOneReg[BIT_INT_CLK_SEL]
    && tick |-> presReg == 7'h7f)
    else $error("phi/128 tick out of phase");
  match_b_set_a: assert property (  // [RQ6]
    $rose(eqB) |=> flagReg[2])
    else $error("match B flag not set");
  match_a_set_a: assert property (  // [RQ7]
    $rose(eqA) |=> flagReg[1])
    else $error("match A flag not set");
  ovf_set_a: assert property (  // [RQ8]
    tick && counting && counterReg == 8'hff |=> flagReg[0]
    ##0 counterReg == 8'h00 || $past(clearNow) || $past(wrDone))
    else $error("overflow flag not set");
  ovf_clear_a: assert property (  // [RQ9]
    $fell(flagReg[0]) |-> $past(armReg[0]) && $past(wrDone)
    && $past(idx) == IDX_CTL_STATUS && !$past(pwdata[BIT_OVF_FLAG]))
    else $error("overflow flag cleared without read-then-write");
  pin_hold_a: assert property (  // [RQ10] [RQ11]
    osA == OUT_KEEP && osB == OUT_KEEP |=> $stable(timerOutputPin))
    else $error("output pin changed with no output select");
  trig_off_a: assert property (  // [RQ12]
    trigSel == 2'b00 |-> !trigEdge)
    else $error("trigger seen while disabled");
  trig_start_a: assert property (  // [RQ13]
    !ctlOneReg[BIT_TRIG_ENABLE] && tick |-> counting)
    else $error("counting halted with trigger disabled");
  flag_hw_only_a: assert property (  // [RQ16]
    $rose(flagReg[0]) |-> $past(ovfEvt))
    else $error("overflow flag set without overflow");

  ovf_irq_c: cover property ($rose(flagReg[0]) ##1 timerIrq);
  match_clear_c: cover property (clrSel == CLR_MATCH_A && matchA);
  ovf_clear_c: cover property ($fell(flagReg[0]));
  trig_start_c: cover property (ctlOneReg[BIT_TRIG_ENABLE] && $rose(runReg));
endmodule
`default_nettype wire

// [tb/cmt_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cmt_timer_tb;
  import cmt_pkg::*;
  logic              clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              triggerInputPin;
  logic              timerOutputPin;
  logic              timerIrq;
  logic [31:0]       seed;
  logic [31:0]       rnd;
  logic [7:0]        rv;
  logic [7:0]        ca;
  logic [7:0]        cb;
  logic              err;
  int                nErrors;
  int                cmpCount;

  cmt_timer i_dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .triggerInputPin (triggerInputPin),
    .timerOutputPin  (timerOutputPin),
    .timerIrq        (timerIrq)
  );

  always #4 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // one apb transfer; upper write data bits are random and must be ignored
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    logic [31:0] r;
    r = xs();
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ADDR_W'({idx, 2'b00});
    pwdata  <= {r[31:8], wd};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rv  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk8(rv, exp);
  endtask

  // wait a number of phi/128 counter ticks
  task automatic run(input int ticks);
    repeat (ticks * 128) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    nErrors++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    triggerInputPin = 1'b0;
    seed = 32'h9d6c_524f;
    nErrors = 0;
    cmpCount = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(IDX_CTL_ZERO, 8'h00);
    rdchk(IDX_CTL_STATUS, 8'h10);
    rdchk(IDX_CTL_ONE, 8'h00);
    apb(1'b0, 16'hff00, 8'h00);
    chk1(err, 1'b1);
    // random compare constants, count phi/128 past both matches
    rnd = xs();
    ca = 8'h04 + (rnd[7:0] & 8'h0f);
    cb = ca + 8'h01;
    wr(IDX_CONST_A, ca);
    wr(IDX_CONST_B, cb);
    wr(IDX_CTL_ONE, 8'h01);
    wr(IDX_CTL_STATUS, 8'h09);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h03);
    run(cb + 3);
    wr(IDX_CTL_ZERO, 8'h00);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv > cb && rv <= cb + 8'h04, 1'b1);
    chk1(timerIrq, 1'b0);
    rdchk(IDX_CTL_STATUS, 8'hd9);
    chk1(timerOutputPin, 1'b1);
    wr(IDX_CTL_ZERO, 8'h40);
    chk1(timerIrq, 1'b1);
    wr(IDX_CTL_ZERO, 8'h80);
    chk1(timerIrq, 1'b1);
    // writes of one, and zero without a prior read, leave flags set
    wr(IDX_CTL_ZERO, 8'h00);
    wr(IDX_CTL_STATUS, 8'he9);
    wr(IDX_CTL_STATUS, 8'h09);
    rdchk(IDX_CTL_STATUS, 8'hd9);
    wr(IDX_CTL_STATUS, 8'h49);
    rdchk(IDX_CTL_STATUS, 8'h59);
    // overflow
    wr(IDX_CTL_ZERO, 8'h20);
    chk1(timerIrq, 1'b0);
    wr(IDX_COUNTER, 8'hfe);
    wr(IDX_CTL_ZERO, 8'h23);
    run(4);
    chk1(timerIrq, 1'b1);
    wr(IDX_CTL_ZERO, 8'h00);
    chk1(timerIrq, 1'b0);
    rdchk(IDX_CTL_STATUS, 8'h79);
    wr(IDX_CTL_STATUS, 8'h01);
    rdchk(IDX_CTL_STATUS, 8'h11);
    // clear on match A, output driven low by match A
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h0b);
    run(ca + 3);
    wr(IDX_CTL_ZERO, 8'h00);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv < ca, 1'b1);
    chk1(timerOutputPin, 1'b0);
    // match A drives high, match B set to keep
    wr(IDX_CTL_STATUS, 8'h02);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h03);
    run(cb + 3);
    wr(IDX_CTL_ZERO, 8'h00);
    chk1(timerOutputPin, 1'b1);
    // event registers: raise, mask, clear
    rdchk(IDX_EVT_STATUS, 8'h07);
    chk1(timerIrq, 1'b0);
    wr(IDX_EVT_ENABLE, 8'h01);
    chk1(timerIrq, 1'b1);
    wr(IDX_EVT_CLEAR, 8'h01);
    chk1(timerIrq, 1'b0);
    rdchk(IDX_EVT_STATUS, 8'h06);
    // trigger enabled but edge select off: no start
    wr(IDX_CTL_ONE, 8'h05);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h03);
    repeat (4)
    begin
      @(posedge clk);
      triggerInputPin <= ~triggerInputPin;
      repeat (4) @(posedge clk);
    end
    run(3);
    rdchk(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ONE, 8'h0d);
    @(posedge clk);
    triggerInputPin <= 1'b1;
    run(3);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv != 8'h00, 1'b1);
    // divide by four with internal select 0: 43 edges give 10 or 11 ticks
    wr(IDX_CTL_ZERO, 8'h00);
    wr(IDX_CTL_ONE, 8'h00);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h01);
    repeat (40) @(posedge clk);
    wr(IDX_CTL_ZERO, 8'h00);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv >= 8'h0a && rv <= 8'h0b, 1'b1);
    // clear on match B, match B toggles the pin exactly once
    wr(IDX_CTL_STATUS, 8'h0c);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_CTL_ZERO, 8'h11);
    repeat ((cb + 2) * 4) @(posedge clk);
    wr(IDX_CTL_ZERO, 8'h00);
    chk1(timerOutputPin, 1'b0);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv < cb, 1'b1);
    // falling trigger edge clears the counter with trigger enable off
    wr(IDX_COUNTER, 8'h40);
    wr(IDX_CTL_ONE, 8'h10);
    wr(IDX_CTL_ZERO, 8'h19);
    @(posedge clk);
    triggerInputPin <= 1'b0;
    repeat (6) @(posedge clk);
    wr(IDX_CTL_ZERO, 8'h00);
    apb(1'b0, IDX_COUNTER, 8'h00);
    chk1(rv < 8'h08, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
